/* design/timer_ch_if.sv */
// Purpose: link between the unit's register side and one channel
// Assumes: pin is already synchronised to pclk
// Notes:   channel outputs come straight from channel flops
`timescale 1ns/1ns
`include "ttu_cfg.svh"
interface timer_ch_if (
    input wire logic pclk,
    input wire logic presetn
);
    logic                    presc_tick;
    logic                    pin;
    logic [`TTU_CTRL_W-1:0]  ctrl;
    logic [`TTU_CNT_W-1:0]   load;
    logic [`TTU_CNT_W-1:0]   cmp;
    logic [`TTU_CNT_W-1:0]   duty;
    logic [`TTU_CNT_W-1:0]   cnt;
    logic [`TTU_CNT_W-1:0]   capt;
    logic                    tc_ev;
    logic                    cap_ev;
    logic                    pout;

    modport unit (input pclk, presetn, cnt, capt, tc_ev, cap_ev, pout,
                  output presc_tick, pin, ctrl, load, cmp, duty);
    modport chan (input pclk, presetn, presc_tick, pin, ctrl, load, cmp,
                  duty, output cnt, capt, tc_ev, cap_ev, pout);
endinterface : timer_ch_if

/* design/timer_channel.sv */
// Purpose: one 24-bit timer / event counter channel
// Assumes: c.pin synchronised, c.ctrl stable from register flops
// Notes:   tc_ev and cap_ev are one-cycle pulses
`timescale 1ns/1ns
`include "ttu_cfg.svh"
module timer_channel (
    timer_ch_if.chan c
);
    ttu_pkg::ch_state_t s_q, s_d;
    logic       rise, fall, edge_hit, base, tick, en, at_tc;
    logic [2:0] mode;

    always_comb begin
        s_d      = s_q;
        s_d.pin_d = c.pin;
        s_d.tc   = 1'b0;
        s_d.cap  = 1'b0;
        mode     = c.ctrl[`TTU_C_MODE];
        en       = c.ctrl[`TTU_C_EN];
        rise     = c.pin & ~s_q.pin_d;
        fall     = ~c.pin & s_q.pin_d;
        case (c.ctrl[`TTU_C_EDGE])
            `TTU_E_RISE: edge_hit = rise;
            `TTU_E_FALL: edge_hit = fall;
            default:     edge_hit = rise | fall;
        endcase
        // selected pin edges, or internal clock optionally through the shared prescaler
        base = c.ctrl[`TTU_C_SRC] ? edge_hit
             : (c.ctrl[`TTU_C_PRE] ? c.presc_tick : 1'b1);
        case (mode)
            `TTU_M_EVENT: tick = edge_hit;
            `TTU_M_WIDTH: tick = base & c.pin;
            default:      tick = base;
        endcase
        at_tc = tick && (s_q.cnt == c.cmp);
        if (!en) begin
            s_d.cnt = c.load;
            s_d.out = 1'b0;
        end else begin
            if (at_tc) begin
                s_d.tc  = 1'b1;
                s_d.cnt = c.load;
            end else if (tick) begin
                s_d.cnt = s_q.cnt + 24'h000001;
            end
            if ((mode == `TTU_M_WIDTH && fall) ||
                (mode == `TTU_M_PERIOD && rise)) begin
                s_d.capt = s_q.cnt;
                s_d.cap  = 1'b1;
                s_d.cnt  = c.load;
            end else if (c.ctrl[`TTU_C_CAPEN] && edge_hit &&
                         mode != `TTU_M_WIDTH && mode != `TTU_M_PERIOD) begin
                s_d.capt = s_q.cnt;
                s_d.cap  = 1'b1;
            end
            case (mode)
                `TTU_M_PULSE: s_d.out = at_tc;
                `TTU_M_PWM:   s_d.out = s_q.cnt < c.duty;
                `TTU_M_WDOG:  s_d.out = s_q.out | at_tc;
                default:      s_d.out = 1'b0;
            endcase
        end
    end

    always_ff @(posedge c.pclk or negedge c.presetn) begin
        if (!c.presetn) s_q <= '0;
        else            s_q <= s_d;
    end

    assign c.cnt    = s_q.cnt;
    assign c.capt   = s_q.capt;
    assign c.tc_ev  = s_q.tc;
    assign c.cap_ev = s_q.cap;
    assign c.pout   = s_q.out;

    default clocking cb @(posedge c.pclk); endclocking
    default disable iff (!c.presetn);

    sequence width_fall_s;
        c.ctrl[`TTU_C_EN] && c.ctrl[`TTU_C_MODE] == `TTU_M_WIDTH
            && !c.pin && s_q.pin_d;
    endsequence

    a_tc_reload: assert property (
        s_q.tc && $stable(c.load) |-> s_q.cnt == c.load)
        else $error("count not reloaded at terminal count");
    a_idle_hold: assert property (
        !c.ctrl[`TTU_C_EN] ##1 $stable(c.load) |-> s_q.cnt == c.load)
        else $error("disabled channel does not hold load value");
    a_width_capt: assert property (
        width_fall_s |=> s_q.cap && s_q.capt == $past(s_q.cnt))
        else $error("pulse width not captured on falling edge");
    a_wdog_sticky: assert property (
        c.ctrl[`TTU_C_EN] && c.ctrl[`TTU_C_MODE] == `TTU_M_WDOG
            && s_q.out ##1 c.ctrl[`TTU_C_EN]
            && c.ctrl[`TTU_C_MODE] == `TTU_M_WDOG |-> s_q.out)
        else $error("watchdog output dropped while enabled");
endmodule : timer_channel

/* design/triple_timer_unit.sv */
// Purpose: three-channel timer / event counter with apb registers
// Assumes: apb master per apb3, pins come from outside pclk domain
// Notes:   reads answer in the first access cycle; status clears on read
//
// Function
// - one shared 21-bit prescaler feeds all channels
// - three identical 24-bit channels, own registers
// - count source: internal clock or pin edges
// - interrupt after programmed count reached
// - channel drives output pin at count
// - dma request at programmed count
// - input pin: count events, measure width/period
// - output pin: pulse, watchdog or pwm
// - unused pin works as software gpio
// - capture counter on selected pin edge
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "ttu_cfg.svh"
module triple_timer_unit (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output wire logic [31:0]           prdata,
    output wire logic                  pready,
    output wire logic                  pslverr,
    input  wire logic [`TTU_NCH-1:0]   timer_pin_in,
    output wire logic [`TTU_NCH-1:0]   timer_pin_out,
    output wire logic [`TTU_NCH-1:0]   timer_pin_oe,
    output wire logic [`TTU_NCH-1:0]   dma_req,
    output wire logic                  irq
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // aligned, below 0x80 and inside the six words of a block
    function automatic logic reg_hit(input logic [7:0] a);
        return (a[7] == 1'b0) && (a[1:0] == 2'h0)
            && (a[4:0] <= `TTU_LAST_OFF);
    endfunction : reg_hit

    function automatic logic is_glb(input logic [7:0] a);
        return a[6:5] == `TTU_GLB_SEL;
    endfunction : is_glb

    ////////////////////////////////////////////////////////////////////
    // declarations

    ttu_pkg::top_state_t s_q, s_d;

    logic                            setup;
    logic                            acc;
    logic                            wr;
    logic                            rd_status;
    logic [1:0]                      chi;
    logic [31:0]                     rd;
    logic                            presc_tick;
    logic [`TTU_STAT_W-1:0]          set_v;
    logic [`TTU_NCH-1:0]             tc_v;
    logic [`TTU_NCH-1:0]             cap_v;
    logic [`TTU_NCH-1:0]             out_v;
    logic [`TTU_NCH-1:0]             pin_en_v;
    logic [`TTU_NCH-1:0]             dma_en_v;
    logic [`TTU_NCH-1:0][`TTU_CNT_W-1:0] cnt_v;
    logic [`TTU_NCH-1:0][`TTU_CNT_W-1:0] capt_v;

    ////////////////////////////////////////////////////////////////////
    // channels

    timer_ch_if ch_if [`TTU_NCH] (.pclk(pclk), .presetn(presetn));

    genvar g;
    generate
        for (g = 0; g < `TTU_NCH; g++) begin : g_ch
            assign ch_if[g].presc_tick = presc_tick;
            assign ch_if[g].pin        = s_q.sync2[g];
            assign ch_if[g].ctrl       = s_q.ctrl[g];
            assign ch_if[g].load       = s_q.load[g];
            assign ch_if[g].cmp        = s_q.cmp[g];
            assign ch_if[g].duty       = s_q.duty[g];
            assign tc_v[g]             = ch_if[g].tc_ev;
            assign cap_v[g]            = ch_if[g].cap_ev;
            assign out_v[g]            = ch_if[g].pout;
            assign cnt_v[g]            = ch_if[g].cnt;
            assign capt_v[g]           = ch_if[g].capt;
            assign pin_en_v[g]         = s_q.ctrl[g][`TTU_C_PIN];
            assign dma_en_v[g]         = s_q.ctrl[g][`TTU_C_DMA];
            assign set_v[2*g]          = ch_if[g].tc_ev;
            assign set_v[2*g+1]        = ch_if[g].cap_ev;
            timer_channel u_ch (
                .c (ch_if[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // bus decode

    // reads are sampled at the setup edge so prdata comes from a flop
    assign setup     = psel & ~penable;
    assign acc       = psel & penable;
    assign wr        = acc & pwrite & reg_hit(paddr);
    assign rd_status = acc & ~pwrite & reg_hit(paddr) & is_glb(paddr)
                     & (paddr[4:0] == `TTU_OFF_STATUS);
    assign chi       = paddr[6:5];
    assign presc_tick = (s_q.presc_cnt == s_q.presc_div);

    always_comb begin
        rd = 32'h00000000;
        if (reg_hit(paddr) && is_glb(paddr)) begin
            case (paddr[4:0])
                `TTU_OFF_PRESC:  rd[`TTU_PRESC_W-1:0] = s_q.presc_div;
                `TTU_OFF_STATUS: rd[`TTU_STAT_W-1:0]  = s_q.status;
                `TTU_OFF_MASK:   rd[`TTU_STAT_W-1:0]  = s_q.mask;
                `TTU_OFF_GDIR:   rd[`TTU_NCH-1:0]     = s_q.gdir;
                `TTU_OFF_GOUT:   rd[`TTU_NCH-1:0]     = s_q.gout;
                `TTU_OFF_GIN:    rd[`TTU_NCH-1:0]     = s_q.sync2;
                default:         rd = 32'h00000000;
            endcase
        end else if (reg_hit(paddr)) begin
            case (paddr[4:0])
                `TTU_OFF_CTRL:  rd[`TTU_CTRL_W-1:0] = s_q.ctrl[chi];
                `TTU_OFF_LOAD:  rd[`TTU_CNT_W-1:0]  = s_q.load[chi];
                `TTU_OFF_CMP:   rd[`TTU_CNT_W-1:0]  = s_q.cmp[chi];
                `TTU_OFF_DUTY:  rd[`TTU_CNT_W-1:0]  = s_q.duty[chi];
                `TTU_OFF_COUNT: rd[`TTU_CNT_W-1:0]  = cnt_v[chi];
                `TTU_OFF_CAPT:  rd[`TTU_CNT_W-1:0]  = capt_v[chi];
                default:        rd = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;

        // pins pass two flops before any logic reads them
        s_d.sync1 = timer_pin_in;
        s_d.sync2 = s_q.sync1;

        // shared prescaler: one tick every presc_div+1 cycles
        s_d.presc_cnt = presc_tick ? '0
                      : s_q.presc_cnt + 21'h000001;

        if (setup) begin
            s_d.prdata = rd;
        end

        if (wr && is_glb(paddr)) begin
            case (paddr[4:0])
                `TTU_OFF_PRESC: s_d.presc_div = pwdata[`TTU_PRESC_W-1:0];
                `TTU_OFF_MASK:  s_d.mask = pwdata[`TTU_STAT_W-1:0];
                `TTU_OFF_GDIR:  s_d.gdir = pwdata[`TTU_NCH-1:0];
                `TTU_OFF_GOUT:  s_d.gout = pwdata[`TTU_NCH-1:0];
                default:        s_d.mask = s_q.mask;
            endcase
        end else if (wr) begin
            case (paddr[4:0])
                `TTU_OFF_CTRL: s_d.ctrl[chi] = pwdata[`TTU_CTRL_W-1:0];
                `TTU_OFF_LOAD: s_d.load[chi] = pwdata[`TTU_CNT_W-1:0];
                `TTU_OFF_CMP:  s_d.cmp[chi]  = pwdata[`TTU_CNT_W-1:0];
                `TTU_OFF_DUTY: s_d.duty[chi] = pwdata[`TTU_CNT_W-1:0];
                default:       s_d.cmp[chi]  = s_q.cmp[chi];
            endcase
        end

        // read clears; an event in the same cycle survives the clear
        s_d.status = (rd_status ? '0 : s_q.status) | set_v;

        s_d.dma = tc_v & dma_en_v;

        // a pin owned by its channel follows the channel's mode;
        // otherwise it is plain gpio
        for (int i = 0; i < `TTU_NCH; i++) begin
            if (pin_en_v[i]) begin
                s_d.pout[i] = out_v[i] ^ s_q.ctrl[i][`TTU_C_INV];
                s_d.poe[i]  = s_q.ctrl[i][`TTU_C_MODE] < `TTU_M_EVENT;
            end else begin
                s_d.pout[i] = s_q.gout[i];
                s_d.poe[i]  = s_q.gdir[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            s_q.presc_div <= `TTU_RST_PRESC;
            s_q.mask      <= `TTU_RST_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata        = s_q.prdata;
    assign pready        = 1'b1;
    assign pslverr       = acc & ~reg_hit(paddr);
    assign timer_pin_out = s_q.pout;
    assign timer_pin_oe  = s_q.poe;
    assign dma_req       = s_q.dma;
    assign irq           = |(s_q.status & s_q.mask);

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence status_read_s;
        acc && !pwrite && is_glb(paddr) && reg_hit(paddr)
            && paddr[4:0] == `TTU_OFF_STATUS;
    endsequence

    sequence tc_dma_s;
        |(tc_v & dma_en_v);
    endsequence

    a_presc_period: assert property (
        presc_tick && s_q.presc_div != '0 && !wr
            |=> !presc_tick)
        else $error("prescaler ticked on consecutive cycles");

    a_status_clear: assert property (
        status_read_s |=> s_q.status == $past(set_v))
        else $error("status not cleared by read");

    a_irq_raise: assert property (
        |(set_v & s_q.mask) && !rd_status && !wr |=> irq)
        else $error("unmasked event did not raise interrupt");

    a_status_keep: assert property (
        |s_q.status && !rd_status |=> |s_q.status)
        else $error("status flag lost without a read");

    a_dma_pulse: assert property (
        tc_dma_s |=> dma_req == $past(tc_v & dma_en_v))
        else $error("dma request missing after terminal count");

    a_gpio_drive: assert property (
        !pin_en_v[0] && s_q.gdir[0] ##1 !pin_en_v[0]
            |-> timer_pin_oe[0] && timer_pin_out[0] == $past(s_q.gout[0]))
        else $error("gpio pin not driven from gpio registers");

    a_in_mode_oe: assert property (
        pin_en_v[2] && s_q.ctrl[2][`TTU_C_MODE] >= `TTU_M_EVENT
            |=> !timer_pin_oe[2])
        else $error("input mode pin is being driven");

    a_pin_follow: assert property (
        pin_en_v[0] && !s_q.ctrl[0][`TTU_C_INV]
            |=> timer_pin_out[0] == $past(out_v[0]))
        else $error("timer pin does not follow channel output");

    a_gin_read: assert property (
        setup && !pwrite && is_glb(paddr) && reg_hit(paddr)
            && paddr[4:0] == `TTU_OFF_GIN
            |=> prdata[`TTU_NCH-1:0] == $past(s_q.sync2))
        else $error("gpio input read wrong");

    a_bad_addr: assert property (
        acc && !reg_hit(paddr) |-> pslverr
            ##1 $stable(s_q.ctrl) && $stable(s_q.mask))
        else $error("unmapped access not flagged or took effect");

endmodule : triple_timer_unit

/* design/ttu_cfg.svh */
// Purpose: constants of the triple timer unit (offsets, fields, resets)
// Assumes: 8-bit apb byte address, one register per aligned word
// Notes:   channel n sits at n*0x20, global registers at 0x60
`ifndef TTU_CFG_SVH
`define TTU_CFG_SVH

`define TTU_NCH        3
`define TTU_PRESC_W    21
`define TTU_CNT_W      24
`define TTU_CTRL_W     12
`define TTU_STAT_W     6
`define TTU_GLB_SEL    2'h3
`define TTU_LAST_OFF   5'h14
// offsets inside a channel block
`define TTU_OFF_CTRL   5'h00
`define TTU_OFF_LOAD   5'h04
`define TTU_OFF_CMP    5'h08
`define TTU_OFF_DUTY   5'h0c
`define TTU_OFF_COUNT  5'h10
`define TTU_OFF_CAPT   5'h14
// offsets inside the global block
`define TTU_OFF_PRESC  5'h00
`define TTU_OFF_STATUS 5'h04
`define TTU_OFF_MASK   5'h08
`define TTU_OFF_GDIR   5'h0c
`define TTU_OFF_GOUT   5'h10
`define TTU_OFF_GIN    5'h14
// control register fields
`define TTU_C_EN       0
`define TTU_C_SRC      1
`define TTU_C_PRE      2
`define TTU_C_MODE     5:3
`define TTU_C_EDGE     7:6
`define TTU_C_PIN      8
`define TTU_C_INV      9
`define TTU_C_DMA      10
`define TTU_C_CAPEN    11
// modes
`define TTU_M_PULSE    3'h0
`define TTU_M_PWM      3'h1
`define TTU_M_WDOG     3'h2
`define TTU_M_EVENT    3'h3
`define TTU_M_WIDTH    3'h4
`define TTU_M_PERIOD   3'h5
// edge selects
`define TTU_E_RISE     2'h0
`define TTU_E_FALL     2'h1
// reset values
`define TTU_RST_PRESC  21'h000000
`define TTU_RST_MASK   6'h00

`endif

/* design/ttu_pkg.sv */
// Purpose: state types of the triple timer unit
// Assumes: ttu_cfg.svh on the include path
// Notes:   one packed struct per module holds all its state
package ttu_pkg;
`include "ttu_cfg.svh"

    typedef struct packed {
        logic [`TTU_PRESC_W-1:0]                  presc_cnt;
        logic [`TTU_PRESC_W-1:0]                  presc_div;
        logic [`TTU_NCH-1:0][`TTU_CTRL_W-1:0]     ctrl;
        logic [`TTU_NCH-1:0][`TTU_CNT_W-1:0]      load;
        logic [`TTU_NCH-1:0][`TTU_CNT_W-1:0]      cmp;
        logic [`TTU_NCH-1:0][`TTU_CNT_W-1:0]      duty;
        logic [`TTU_STAT_W-1:0]                   status;
        logic [`TTU_STAT_W-1:0]                   mask;
        logic [`TTU_NCH-1:0]                      gdir;
        logic [`TTU_NCH-1:0]                      gout;
        logic [`TTU_NCH-1:0]                      sync1;
        logic [`TTU_NCH-1:0]                      sync2;
        logic [`TTU_NCH-1:0]                      pout;
        logic [`TTU_NCH-1:0]                      poe;
        logic [`TTU_NCH-1:0]                      dma;
        logic [31:0]                              prdata;
    } top_state_t;

    typedef struct packed {
        logic [`TTU_CNT_W-1:0] cnt;
        logic [`TTU_CNT_W-1:0] capt;
        logic                  pin_d;
        logic                  out;
        logic                  tc;
        logic                  cap;
    } ch_state_t;

endpackage : ttu_pkg

/* dv/pin_source.sv */
// Purpose: far-side model of the sources wired to the timer pins
// Assumes: a pin the unit drives shows the unit's own level
// Notes:   an undriven pin toggles so a stale level never passes
`timescale 1ns/1ns
module pin_source (
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic       pclk,
    output logic      [2:0] pin_in
);
    logic [2:0] lvl;
    logic [2:0] drv_en;
    logic       tog;
    initial begin
        lvl    = 3'h0;
        drv_en = 3'h0;
        tog    = 1'b0;
    end
    always @(posedge pclk) tog <= ~tog;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? lvl[i] : tog);
        end
    end
    task automatic hold(input int i, input logic v);
        @(posedge pclk);
        drv_en[i] <= 1'b1;
        lvl[i]    <= v;
    endtask : hold
    // three cycles per level so every edge survives the sync flops
    task automatic pulses(input int i, input int n);
        repeat (n) begin
            hold(i, 1'b1);
            repeat (2) @(posedge pclk);
            hold(i, 1'b0);
            repeat (2) @(posedge pclk);
        end
    endtask : pulses
endmodule : pin_source

/* dv/triple_timer_unit_bench.sv */
// Purpose: self-checking bench of the triple timer unit
// Assumes: zero wait state apb slave, one pclk domain
// Notes:   apb answers are checked from a queue by a monitor
`timescale 1ns/1ns
`include "ttu_cfg.svh"
module triple_timer_unit_bench;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [7:0]          paddr;
    logic [31:0]         pwdata;
    wire  [31:0]         prdata;
    wire                 pready;
    wire                 pslverr;
    wire  [`TTU_NCH-1:0] pin_in;
    wire  [`TTU_NCH-1:0] pin_out;
    wire  [`TTU_NCH-1:0] pin_oe;
    wire  [`TTU_NCH-1:0] dma_req;
    wire                 irq;
    int                  fails;
    int                  total_checks;
    int                  cyc;
    int                  n;
    int                  dma2_cnt;
    integer              seed;
    logic [32:0]         expq[$];
    logic [32:0]         e;
    logic [23:0]         ldv;
    logic [20:0]         pre;

    triple_timer_unit u_triple_timer_unit (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_pin_in(pin_in),
        .timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
        .dma_req(dma_req), .irq(irq)
    );
    pin_source u_pin_source (
        .pin_out(pin_out), .pin_oe(pin_oe), .pclk(pclk), .pin_in(pin_in)
    );

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic [7:0] ra(input logic [1:0] ch,
                                      input logic [4:0] off);
        return {1'b0, ch, off};
    endfunction : ra
    // for a read, d carries the expected data
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic err);
        // idle edge: psel is never lowered and raised in one time step
        @(posedge pclk);
        expq.push_back({err, d});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d, 1'b0);
    endtask : rd
    task automatic period(input int ch, input int exp);
        int k;
        k = 0;
        while (dma_req[ch] !== 1'b1 && k < 500) begin
            @(posedge pclk);
            k++;
        end
        @(posedge pclk);
        k = 1;
        while (dma_req[ch] !== 1'b1 && k < 500) begin
            @(posedge pclk);
            k++;
        end
        check("dma period", 32'(exp), 32'(k));
    endtask : period
    task automatic count_high(input int ch, input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge pclk);
            if (pin_out[ch] === 1'b1) n++;
        end
    endtask : count_high
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            e = expq.pop_front();
            check("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (pwrite === 1'b0) check("prdata", e[31:0], prdata);
        end
        if (dma_req[2] === 1'b1) dma2_cnt++;
        cyc++;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hf49e;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_PRESC), 32'h0);
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_MASK), 32'h0);
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_STATUS), 32'h0);
        xfer(1'b0, 8'h78, 32'h0, 1'b1);
        xfer(1'b1, 8'h80, 32'hffffffff, 1'b1);
        // channel 0: periodic reload, pulse out, dma and interrupt
        ldv = 24'($random(seed)) & 24'hfff000;
        wr(ra(2'h0, `TTU_OFF_LOAD), {8'h0, ldv});
        wr(ra(2'h0, `TTU_OFF_CMP), {8'h0, ldv + 24'h2});
        wr(ra(`TTU_GLB_SEL, `TTU_OFF_MASK), 32'h1);
        wr(ra(2'h0, `TTU_OFF_CTRL), 32'h501);
        period(0, 3);
        count_high(0, 6);
        check("pulse count", 32'h2, 32'(n));
        check("pin0 oe", 32'h1, {31'h0, pin_oe[0]});
        wr(ra(2'h0, `TTU_OFF_CTRL), 32'h0);
        repeat (4) @(posedge pclk);
        check("irq set", 32'h1, {31'h0, irq});
        wr(ra(2'h0, `TTU_OFF_COUNT), 32'h0);
        rd(ra(2'h0, `TTU_OFF_COUNT), {8'h0, ldv});
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_STATUS), 32'h1);
        repeat (2) @(posedge pclk);
        check("irq clear", 32'h0, {31'h0, irq});
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_STATUS), 32'h0);
        // channel 1: shared prescaler, then pwm and watchdog
        pre = (21'($random(seed)) & 21'h3) + 21'h1;
        wr(ra(`TTU_GLB_SEL, `TTU_OFF_PRESC), {11'h0, pre});
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_PRESC), {11'h0, pre});
        wr(ra(2'h1, `TTU_OFF_LOAD), 32'h0);
        wr(ra(2'h1, `TTU_OFF_CMP), 32'h1);
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h405);
        period(1, 2 * (int'(pre) + 1));
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h0);
        wr(ra(2'h1, `TTU_OFF_CMP), 32'h3);
        wr(ra(2'h1, `TTU_OFF_DUTY), 32'h2);
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h109);
        repeat (4) @(posedge pclk);
        count_high(1, 8);
        check("pwm high", 32'h4, 32'(n));
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h0);
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h111);
        repeat (10) @(posedge pclk);
        check("watchdog out", 32'h1, {31'h0, pin_out[1]});
        wr(ra(2'h1, `TTU_OFF_CTRL), 32'h0);
        repeat (4) @(posedge pclk);
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_STATUS), 32'h4);
        // channel 2: falling pin edges counted, captured, dma every 4
        u_pin_source.hold(2, 1'b0);
        wr(ra(2'h2, `TTU_OFF_LOAD), 32'h0);
        wr(ra(2'h2, `TTU_OFF_CMP), 32'h3);
        wr(ra(2'h2, `TTU_OFF_CTRL), 32'hd5b);
        dma2_cnt = 0;
        u_pin_source.pulses(2, 8);
        repeat (6) @(posedge pclk);
        check("event dma", 32'h2, 32'(dma2_cnt));
        wr(ra(2'h2, `TTU_OFF_CTRL), 32'h0);
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_STATUS), 32'h30);
        // channel 2: width of a random pulse, then period of a train
        wr(ra(2'h2, `TTU_OFF_CMP), 32'hff);
        wr(ra(2'h2, `TTU_OFF_CTRL), 32'h121);
        n = 2 + ($random(seed) & 3);
        u_pin_source.hold(2, 1'b1);
        repeat (n) @(posedge pclk);
        u_pin_source.hold(2, 1'b0);
        repeat (4) @(posedge pclk);
        rd(ra(2'h2, `TTU_OFF_CAPT), 32'(n + 1));
        wr(ra(2'h2, `TTU_OFF_CTRL), 32'h129);
        u_pin_source.pulses(2, 2);
        repeat (4) @(posedge pclk);
        rd(ra(2'h2, `TTU_OFF_CAPT), 32'h5);
        wr(ra(2'h2, `TTU_OFF_CTRL), 32'h0);
        // free pins as software gpio
        wr(ra(`TTU_GLB_SEL, `TTU_OFF_GDIR), 32'h1);
        wr(ra(`TTU_GLB_SEL, `TTU_OFF_GOUT), 32'h1);
        u_pin_source.hold(1, 1'b0);
        u_pin_source.hold(2, 1'b1);
        repeat (4) @(posedge pclk);
        check("gpio out", 32'h3, {30'h0, pin_oe[0], pin_out[0]});
        rd(ra(`TTU_GLB_SEL, `TTU_OFF_GIN), 32'h5);
        repeat (2) @(posedge pclk);
        tally_and_finish();
    end
endmodule : triple_timer_unit_bench
